// file: rtl/rsb_reset_boot.sv
`timescale 1ns/1ps
module rsb_reset_boot #(
    parameter int unsigned STRETCH = rsb_pkg::STRETCH_CYCLES
) (
    // clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_N_I,
    // carrier reset request and straps
    input  wire logic       RESET_REQ_N_I,
    input  wire logic       BOOT_PICK_BIT0_N_I,
    input  wire logic       BOOT_PICK_BIT1_N_I,
    input  wire logic       BOOT_PICK_BIT2_N_I,
    input  wire logic       SD_OVERRIDE_N_I,
    // resets out
    output logic            INT_RESET_N_O,
    output logic            RESET_OUT_N_O,
    // boot selection
    output logic            BOOT_START_O,
    output logic [2:0]      BOOT_CODE_O,
    output logic [7:0]      BOOT_SRC_O,
    output logic            FIRST_STAGE_SD_O,
    output logic            SRC_UNSUPPORTED_O
);
    typedef enum logic [1:0] {RSB_HOLD, RSB_STRETCH, RSB_RUN} rsb_state_t;

    rsb_state_t                   state;
    logic [1:0]                   req_sync;
    logic [3:0]                   pick_s1;
    logic [3:0]                   pick_s2;
    logic [rsb_pkg::CNT_W-1:0]    cnt;
    logic                         stretch_done;

    // code to one-hot source
    function automatic logic [7:0] rsb_decode(input logic [2:0] code);
        unique case (code)
            rsb_pkg::CODE_CARRIER_SATA: rsb_decode = rsb_pkg::RSB_SRC_SATA;
            rsb_pkg::CODE_CARRIER_SD:   rsb_decode = rsb_pkg::RSB_SRC_SD;
            rsb_pkg::CODE_CARRIER_ESPI: rsb_decode = rsb_pkg::RSB_SRC_ESPI;
            rsb_pkg::CODE_CARRIER_SPI:  rsb_decode = rsb_pkg::RSB_SRC_SPI;
            rsb_pkg::CODE_MODULE_USB:   rsb_decode = rsb_pkg::RSB_SRC_USB;
            rsb_pkg::CODE_NET_BOOT:     rsb_decode = rsb_pkg::RSB_SRC_NET;
            rsb_pkg::CODE_MODULE_EMMC:  rsb_decode = rsb_pkg::RSB_SRC_EMMC;
            rsb_pkg::CODE_MODULE_SPI:   rsb_decode = rsb_pkg::RSB_SRC_MSPI;
        endcase
    endfunction

    // request synchroniser; stage 0 feeds only stage 1
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            req_sync <= 2'h0;
        end else begin
            req_sync <= {req_sync[0], RESET_REQ_N_I};
        end
    end

    // strap synchronisers, pull-ups read as 1
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pick_s1 <= 4'hF;
            pick_s2 <= 4'hF;
        end else begin
            pick_s1 <= {SD_OVERRIDE_N_I, BOOT_PICK_BIT2_N_I, BOOT_PICK_BIT1_N_I, BOOT_PICK_BIT0_N_I};
            pick_s2 <= pick_s1;
        end
    end

    assign stretch_done = (cnt == rsb_pkg::CNT_W'(STRETCH - 1));

    // sequencer: hold while requested, then stretch, then run
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= RSB_HOLD;
            cnt   <= '0;
        end else if (!req_sync[1]) begin
            state <= RSB_HOLD;
            cnt   <= '0;
        end else begin
            unique case (state)
                RSB_HOLD: begin
                    state <= RSB_STRETCH;
                    cnt   <= '0;
                end
                RSB_STRETCH: begin
                    if (stretch_done) begin
                        state <= RSB_RUN;
                    end
                    cnt <= cnt + 1'b1;
                end
                RSB_RUN: begin
                    state <= RSB_RUN;
                end
            endcase
        end
    end

    // reset outputs from flops, low until run
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INT_RESET_N_O <= 1'b0;
            RESET_OUT_N_O <= 1'b0;
            BOOT_START_O  <= 1'b0;
        end else begin
            INT_RESET_N_O <= (state == RSB_STRETCH && stretch_done && req_sync[1]) ||
                             (state == RSB_RUN && req_sync[1]);
            RESET_OUT_N_O <= (state == RSB_STRETCH && stretch_done && req_sync[1]) ||
                             (state == RSB_RUN && req_sync[1]);
            BOOT_START_O  <= state == RSB_STRETCH && stretch_done && req_sync[1];
        end
    end

    // latch straps as the stretch ends
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            BOOT_CODE_O       <= rsb_pkg::CODE_RESET;
            BOOT_SRC_O        <= rsb_pkg::RSB_SRC_MSPI;
            FIRST_STAGE_SD_O  <= 1'b0;
            SRC_UNSUPPORTED_O <= 1'b1;
        end else if (state == RSB_STRETCH && stretch_done && req_sync[1]) begin
            BOOT_CODE_O       <= pick_s2[2:0];
            BOOT_SRC_O        <= rsb_decode(pick_s2[2:0]);
            FIRST_STAGE_SD_O  <= ~pick_s2[3];
            SRC_UNSUPPORTED_O <= pick_s2[2:0] == rsb_pkg::CODE_CARRIER_SPI ||
                                 pick_s2[2:0] == rsb_pkg::CODE_MODULE_SPI;
        end
    end

    // low-count helper for the stretch check
    logic [rsb_pkg::CNT_W-1:0] low_run;
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            low_run <= '0;
        end else if (RESET_OUT_N_O) begin
            low_run <= '0;
        end else if (req_sync[1] && low_run != '1) begin
            low_run <= low_run + 1'b1;
        end
    end

    // cycles since the last release with the resets still low; restarts on every request
    logic [rsb_pkg::CNT_W-1:0] rel_run;
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rel_run <= '0;
        end else if (RESET_OUT_N_O || !req_sync[1]) begin
            rel_run <= '0;
        end else if (rel_run != '1) begin
            rel_run <= rel_run + 1'b1;
        end
    end

    sequence s_released;
        $rose(req_sync[1]);
    endsequence

    sequence s_out_held_low;
        (!RESET_OUT_N_O) [*8];
    endsequence

    sequence s_boot_pulse;
        BOOT_START_O ##1 !BOOT_START_O;
    endsequence

    a_hold_while_req: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !req_sync[1] |=> !INT_RESET_N_O && !RESET_OUT_N_O)
        else $error("reset released while request held");

    a_stretch_min_len: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        $rose(RESET_OUT_N_O) |-> $past(low_run) >= rsb_pkg::CNT_W'(STRETCH))
        else $error("reset stretch shorter than minimum");

    a_release_bounded: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_released |-> s_out_held_low)
        else $error("reset released too soon after request");

    a_release_deadline: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        rel_run <= rsb_pkg::CNT_W'(STRETCH + 1))
        else $error("reset not released in time after request");

    a_restart_full: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        $rose(RESET_OUT_N_O) |-> $past(rel_run) >= rsb_pkg::CNT_W'(STRETCH))
        else $error("stretch not restarted after request");

    a_start_one_cycle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        BOOT_START_O |-> s_boot_pulse)
        else $error("boot start wider than one cycle");

    a_start_with_release: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        BOOT_START_O |-> RESET_OUT_N_O && !$past(RESET_OUT_N_O))
        else $error("boot start without reset release");

    a_outs_together: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        INT_RESET_N_O == RESET_OUT_N_O)
        else $error("internal and output reset differ");

    a_code_latched: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        BOOT_START_O |-> BOOT_CODE_O == $past(pick_s2[2:0]))
        else $error("boot code not latched at stretch end");

    a_src_decoded: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        BOOT_START_O |-> BOOT_SRC_O == (8'h01 << BOOT_CODE_O))
        else $error("boot source does not match code");

    a_spi_flagged: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        BOOT_START_O |-> SRC_UNSUPPORTED_O == (BOOT_CODE_O[1:0] == 2'h3))
        else $error("spi source not flagged");

    a_sd_override: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        BOOT_START_O |-> FIRST_STAGE_SD_O == !$past(pick_s2[3]))
        else $error("first stage medium wrong");

    a_stable_in_run: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        RESET_OUT_N_O && !BOOT_START_O |-> $stable(BOOT_CODE_O) && $stable(FIRST_STAGE_SD_O))
        else $error("boot selection changed while running");
endmodule

// file: shared/rsb_pkg.sv
package rsb_pkg;
    // clock and stretch timing
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned STRETCH_US       = 1000;          // 1 ms minimum stretch
    localparam int unsigned STRETCH_CYCLES   = (CLK_HZ / 1_000_000) * STRETCH_US;
    localparam int          CNT_W            = 16;
    // boot-pick codes, msb first, ground reads 0
    localparam logic [2:0]  CODE_CARRIER_SATA = 3'h0;
    localparam logic [2:0]  CODE_CARRIER_SD   = 3'h1;
    localparam logic [2:0]  CODE_CARRIER_ESPI = 3'h2;
    localparam logic [2:0]  CODE_CARRIER_SPI  = 3'h3;
    localparam logic [2:0]  CODE_MODULE_USB   = 3'h4;
    localparam logic [2:0]  CODE_NET_BOOT     = 3'h5;
    localparam logic [2:0]  CODE_MODULE_EMMC  = 3'h6;
    localparam logic [2:0]  CODE_MODULE_SPI   = 3'h7;
    localparam logic [2:0]  CODE_RESET        = 3'h7;     // value while straps float
    // boot sources, one-hot over the eight codes
    typedef enum logic [7:0] {
        RSB_SRC_SATA = 8'h01,
        RSB_SRC_SD   = 8'h02,
        RSB_SRC_ESPI = 8'h04,
        RSB_SRC_SPI  = 8'h08,
        RSB_SRC_USB  = 8'h10,
        RSB_SRC_NET  = 8'h20,
        RSB_SRC_EMMC = 8'h40,
        RSB_SRC_MSPI = 8'h80
    } rsb_src_t;
endpackage

// file: sim/rsb_carrier_model.sv
`timescale 1ns/1ps
module rsb_carrier_model (
    // commands from the bench
    input  wire logic       req_i,
    input  wire logic [2:0] code_i,
    input  wire logic       ovr_i,
    input  wire logic       off_i,
    // lines towards the module
    output logic            req_n_o,
    output logic [2:0]      pick_n_o,
    output logic            ovr_n_o,
    output logic            rail_lo_o,
    output logic            rail_hi_o
);
    logic off_d;
    // straps are grounded (0) or left floating on the module pull-up (1)
    assign pick_n_o = code_i;
    assign ovr_n_o  = ~ovr_i;
    assign req_n_o  = ~req_i;
    // low rail drops at once, high rail follows later
    assign #100 off_d = off_i;
    assign rail_hi_o = ~off_d;
    assign rail_lo_o = ~off_i & rail_hi_o;
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned STRETCH = 20;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req = 1'b0;
    logic [2:0]  code = 3'h0;
    logic        ovr = 1'b0;
    logic        off = 1'b0;
    logic        req_n, ovr_n, rail_lo, rail_hi, int_n, out_n, start, sd, unsup;
    logic [2:0]  pick_n, bcode;
    logic [7:0]  src;
    logic [31:0] seed = 32'hc22f_8540;
    int          failures = 0;
    int          total_checks = 0;
    int          n;
    // 25 MHz clock
    always #20 clk = ~clk;
    rsb_carrier_model u_car (.req_i(req), .code_i(code), .ovr_i(ovr), .off_i(off), .req_n_o(req_n),
        .pick_n_o(pick_n), .ovr_n_o(ovr_n), .rail_lo_o(rail_lo), .rail_hi_o(rail_hi));
    rsb_reset_boot #(.STRETCH(STRETCH)) u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .RESET_REQ_N_I(req_n),
        .BOOT_PICK_BIT0_N_I(pick_n[0]), .BOOT_PICK_BIT1_N_I(pick_n[1]), .BOOT_PICK_BIT2_N_I(pick_n[2]),
        .SD_OVERRIDE_N_I(ovr_n), .INT_RESET_N_O(int_n), .RESET_OUT_N_O(out_n), .BOOT_START_O(start),
        .BOOT_CODE_O(bcode), .BOOT_SRC_O(src), .FIRST_STAGE_SD_O(sd), .SRC_UNSUPPORTED_O(unsup));
    // xorshift source for repeatable stimulus
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // spi sources are flagged as not bootable
    function automatic logic exp_unsup(input logic [2:0] c);
        return (c == 3'h3) || (c == 3'h7);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // bounded wait for the resets to rise; n counts the clock edges taken
    task automatic wait_up;
        n = 0;
        while (int_n !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 200) begin
            failures++;
            close_out();
        end
    endtask
    // outputs at the stretch end and one cycle later
    task automatic check_boot;
        chk(8'(n), 8'(STRETCH + 3));
        chk({6'h0, out_n, start}, 8'h03);
        chk({5'h0, bcode}, {5'h0, code});
        chk(src, 8'h01 << code);
        chk({6'h0, sd, unsup}, {6'h0, ovr, exp_unsup(code)});
        @(posedge clk);
        #1;
        chk({7'h0, start}, 8'h00);
    endtask
    // request pulse, optional re-request mid stretch, then timed release
    task automatic pulse_boot(input int len, input int gap);
        @(negedge clk) req = 1'b1;
        repeat (len) @(negedge clk);
        chk({6'h0, int_n, out_n}, 8'h00);
        req = 1'b0;
        if (gap > 0) begin
            repeat (gap) @(negedge clk);
            chk({7'h0, int_n}, 8'h00);
            req = 1'b1;
            @(negedge clk) req = 1'b0;
        end
        wait_up();
    endtask
    // walk all eight codes with random pulse length, random override on codes 0 to 5
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = nxt(seed);
            @(negedge clk);
            code = 3'(i);
            ovr = (i >= 6) ? (i == 6) : seed[0];    // corner: both override levels
            pulse_boot(3 + int'(seed[3:2]), (i == 5) ? 8 : 0);
            check_boot();
        end
        // reset in mid-run with fresh straps: reset values, then a full stretch
        seed = nxt(seed);
        @(negedge clk);
        code = seed[6:4];
        ovr = seed[7];
        rst_n = 1'b0;
        @(negedge clk);
        chk({5'h0, int_n, out_n, start}, 8'h00);
        chk({5'h0, bcode}, 8'h07);
        chk(src, 8'h80);
        chk({6'h0, sd, unsup}, 8'h01);
        rst_n = 1'b1;
        wait_up();
        check_boot();
        off = 1'b1;
        #50;
        chk({6'h0, rail_lo, rail_hi}, 8'h01);
        #100;
        chk({6'h0, rail_lo, rail_hi}, 8'h00);
        close_out();
    end
endmodule
